// ===== rtl/isir_regs.sv
// register file, flags and interrupt of a two-wire master/slave controller
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module isir_regs
   import isir_pkg::*;
(
   input  wire logic              sys_clk,  // system clock, 40 MHz
   input  wire logic              srst,     // sync reset, active high
   input  wire logic              psel,     // apb select
   input  wire logic              penable,  // apb access phase
   input  wire logic              pwrite,   // apb direction
   input  wire logic [ADDR_W-1:0] paddr,    // apb byte address
   input  wire logic [31:0]       pwdata,   // apb write data
   output logic      [31:0]       prdata,   // apb read data
   output logic                   pready,   // apb ready
   output logic                   pslverr,  // apb error, unmapped
   input  wire isir_evt_t         evt,      // bit engine events
   output logic      [7:0]        tx_byte,  // byte for the engine
   output logic                   tx_full,  // tx holding loaded
   output logic                   master_en,// master mode enable
   output logic                   slave_en, // slave mode enable
   input  wire logic              scl_i,    // serial clock pin level
   output logic                   scl_o,    // serial clock drive value
   output logic                   scl_oe,   // serial clock drive enable
   output logic                   irq       // level interrupt
);

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic        acc;
   logic        done;
   logic        wr_done;
   logic        rd_done;
   logic [31:0] rd_word;
   logic        rd_ok;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // one wait state: ready rises on the second access cycle
   assign acc     = psel && penable && !pready;
   assign done    = psel && penable && pready;
   assign wr_done = done && pwrite;
   assign rd_done = done && !pwrite;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [31:0]         mask_reg;
   logic [7:0]          rx_byte_reg;
   logic                done_reg;
   logic                svread_reg;
   logic                svsel_reg;
   logic                rxready_reg;
   logic                txfree_reg;
   logic                gcall_reg;
   logic                ovr_reg;
   logic                nack_reg;
   logic                arb_reg;
   logic                svend_reg;
   logic                stretch_reg;
   logic                wait_pend_reg;
   logic                scl_s1_reg;
   logic                scl_s2_reg;
   logic [31:0]         flag_word;
   logic [NCH-1:0]      dma_end;
   logic [NCH-1:0]      dma_buf;
   logic [CNT_W-1:0]    dma_cnt  [NCH];
   logic [CNT_W-1:0]    dma_next [NCH];
   logic                flag_rd;
   logic [31:0]         flag_clr;

   // read of the flag register and explicit clear writes
   assign flag_rd  = rd_done && hit(paddr, OFF_FLAG);
   assign flag_clr = (wr_done && hit(paddr, OFF_FLAG_CLR)) ? pwdata : 32'h00000000;

   // ---------------------------------------------------------------
   // dma counter pairs
   // ---------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_dma
         localparam logic [ADDR_W-1:0] OC = (ch == CH_RX) ? OFF_RX_CNT  : OFF_TX_CNT;
         localparam logic [ADDR_W-1:0] ON = (ch == CH_RX) ? OFF_RX_NEXT : OFF_TX_NEXT;
         isir_dma_ctr #(.W(CNT_W)) u_ctr (
            .sys_clk  (sys_clk),
            .srst     (srst),
            .wr_cnt   (wr_done && hit(paddr, OC)),
            .wr_next  (wr_done && hit(paddr, ON)),
            .wdata    (pwdata[CNT_W-1:0]),
            .xfer     (evt.dma_xfer[ch]),
            .cnt      (dma_cnt[ch]),
            .next_cnt (dma_next[ch]),
            .end_flag (dma_end[ch]),
            .buf_flag (dma_buf[ch])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // flag word
   // ---------------------------------------------------------------
   // end flag hides while a slave access is still running
   always_comb begin
      flag_word              = 32'h00000000;
      flag_word[BIT_DONE]    = done_reg;
      flag_word[BIT_RXREADY] = rxready_reg;
      flag_word[BIT_TXFREE]  = txfree_reg;
      flag_word[BIT_SVREAD]  = svread_reg;
      flag_word[BIT_SVSEL]   = svsel_reg;
      flag_word[BIT_GCALL]   = gcall_reg;
      flag_word[BIT_OVR]     = ovr_reg;
      flag_word[BIT_NACK]    = nack_reg;
      flag_word[BIT_ARB]     = arb_reg;
      flag_word[BIT_STRETCH] = stretch_reg;
      flag_word[BIT_SVEND]   = svend_reg && !svsel_reg;
      flag_word[BIT_RXEND]   = dma_end[CH_RX];
      flag_word[BIT_TXEND]   = dma_end[CH_TX];
      flag_word[BIT_RXFULL]  = dma_buf[CH_RX];
      flag_word[BIT_TXEMPTY] = dma_buf[CH_TX];
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_word = 32'h00000000;
      rd_ok   = 1'b1;
      unique case (paddr)
         OFF_CTRL:     rd_word = {30'h00000000, slave_en, master_en};
         OFF_FLAG:     rd_word = flag_word;
         OFF_IRQ_MASK: rd_word = mask_reg;
         OFF_RX_HOLD:  rd_word = {24'h000000, rx_byte_reg};
         OFF_TX_HOLD:  rd_word = {24'h000000, tx_byte};
         OFF_RX_CNT:   rd_word = {16'h0000, dma_cnt[CH_RX]};
         OFF_RX_NEXT:  rd_word = {16'h0000, dma_next[CH_RX]};
         OFF_TX_CNT:   rd_word = {16'h0000, dma_cnt[CH_TX]};
         OFF_TX_NEXT:  rd_word = {16'h0000, dma_next[CH_TX]};
         OFF_IRQ_SET, OFF_IRQ_CLR, OFF_FLAG_CLR: rd_word = 32'h00000000;
         default:      rd_ok = 1'b0;
      endcase
   end

   // bus answer; write-only registers read as zero without error
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc;
         pslverr <= acc && !rd_ok;
         if (acc) begin
            prdata <= pwrite ? 32'h00000000 : rd_word;
         end
      end
   end

   // ---------------------------------------------------------------
   // control and mask registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         master_en <= 1'b0;
         slave_en  <= 1'b0;
      end else if (wr_done && hit(paddr, OFF_CTRL)) begin
         master_en <= pwdata[BIT_MASTER];
         slave_en  <= pwdata[BIT_SLAVE];
      end
   end

   // only ones act, so sources are enabled without read-modify-write
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mask_reg <= MASK_RST;
      end else if (wr_done && hit(paddr, OFF_IRQ_SET)) begin
         mask_reg <= mask_reg | (pwdata & IRQ_BITS);
      end else if (wr_done && hit(paddr, OFF_IRQ_CLR)) begin
         mask_reg <= mask_reg & ~(pwdata & IRQ_BITS);
      end
   end

   // ---------------------------------------------------------------
   // holding registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tx_byte <= BYTE_RST;
      end else if (wr_done && hit(paddr, OFF_TX_HOLD)) begin
         tx_byte <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_byte_reg <= BYTE_RST;
      end else if (evt.rx_valid) begin
         rx_byte_reg <= evt.rx_byte;
      end
   end

   // tx free: take or master enable beats a write; resets as the flag word says
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         txfree_reg <= FLAG_RST[BIT_TXFREE];
         tx_full    <= 1'b0;
      end else if (evt.tx_take || (wr_done && hit(paddr, OFF_CTRL) && pwdata[BIT_MASTER])) begin
         txfree_reg <= 1'b1;
         tx_full    <= 1'b0;
      end else if (wr_done && hit(paddr, OFF_TX_HOLD)) begin
         txfree_reg <= 1'b0;
         tx_full    <= 1'b1;
      end
   end

   // rx ready: a new byte beats the read that empties the register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rxready_reg <= 1'b0;
      end else if (evt.rx_valid) begin
         rxready_reg <= 1'b1;
      end else if (rd_done && hit(paddr, OFF_RX_HOLD)) begin
         rxready_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // engine levels and clear-on-read flags
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         done_reg   <= FLAG_RST[BIT_DONE];
         svread_reg <= FLAG_RST[BIT_SVREAD];
         svsel_reg  <= FLAG_RST[BIT_SVSEL];
      end else begin
         done_reg   <= evt.transfer_done;
         svread_reg <= evt.sv_read;
         svsel_reg  <= evt.sv_acc;
      end
   end

   // set wins over read-clear; overrun read-clears only once transfer is done
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gcall_reg <= 1'b0;
         nack_reg  <= 1'b0;
         arb_reg   <= 1'b0;
         ovr_reg   <= 1'b0;
         svend_reg <= 1'b0;
      end else begin
         gcall_reg <= evt.gen_call || (gcall_reg && !flag_rd && !flag_clr[BIT_GCALL]);
         nack_reg  <= evt.nack     || (nack_reg  && !flag_rd && !flag_clr[BIT_NACK]);
         arb_reg   <= evt.arb_lost || (arb_reg   && !flag_rd && !flag_clr[BIT_ARB]);
         ovr_reg   <= (evt.rx_valid && rxready_reg && master_en)
                    || (ovr_reg && !(flag_rd && done_reg) && !flag_clr[BIT_OVR]);
         svend_reg <= (svsel_reg && !evt.sv_acc)
                    || (svend_reg && !evt.sv_acc && !flag_rd && !flag_clr[BIT_SVEND]);
      end
   end

   // ---------------------------------------------------------------
   // serial clock stretch
   // ---------------------------------------------------------------
   logic need_wait;

   // first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
      end else begin
         scl_s1_reg <= scl_i;
         scl_s2_reg <= scl_s1_reg;
      end
   end

   // slave must wait while holding data is not ready for the next byte
   assign need_wait = slave_en && svsel_reg && (svread_reg ? txfree_reg : rxready_reg);

   // grab the line only once it is already low, so no short pulse
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wait_pend_reg <= 1'b0;
         stretch_reg   <= 1'b0;
         scl_o         <= 1'b0;
         scl_oe        <= 1'b0;
      end else begin
         wait_pend_reg <= svsel_reg && !stretch_reg && (evt.char_due || wait_pend_reg);
         stretch_reg   <= need_wait && (stretch_reg || (wait_pend_reg && !scl_s2_reg));
         scl_o         <= 1'b0;
         scl_oe        <= need_wait && (stretch_reg || (wait_pend_reg && !scl_s2_reg));
      end
   end

   // ---------------------------------------------------------------
   // interrupt
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flag_word & mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence set_write_s;
      wr_done && hit(paddr, OFF_IRQ_SET);
   endsequence
   sequence clr_write_s;
      wr_done && hit(paddr, OFF_IRQ_CLR);
   endsequence

   mask_set_a: assert property (@(posedge sys_clk) disable iff (srst)
      set_write_s |=> ((mask_reg & ($past(pwdata) & IRQ_BITS)) == ($past(pwdata) & IRQ_BITS)))
      else $error("enable-set write did not set mask bits");
   mask_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
      clr_write_s |=> ((mask_reg & $past(pwdata)) == 32'h00000000))
      else $error("enable-clear write did not clear mask bits");
   mask_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      (rd_done && hit(paddr, OFF_IRQ_MASK)) |-> (prdata == mask_reg))
      else $error("mask read does not show mask");
   mask_layout_a: assert property (@(posedge sys_clk) disable iff (srst)
      (mask_reg & ~IRQ_BITS) == 32'h00000000)
      else $error("mask bit outside source layout");
   rx_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      (rd_done && hit(paddr, OFF_RX_HOLD)) |-> (prdata == {24'h000000, rx_byte_reg}))
      else $error("rx holding read wrong");
   tx_write_a: assert property (@(posedge sys_clk) disable iff (srst)
      (wr_done && hit(paddr, OFF_TX_HOLD)) |=> (tx_byte == $past(pwdata[7:0]) && tx_full))
      else $error("tx holding write lost");
   flag_reset_a: assert property (@(posedge sys_clk)
      srst |=> (flag_word == FLAG_RST && mask_reg == MASK_RST))
      else $error("flag register reset value wrong");
   irq_level_a: assert property (@(posedge sys_clk) disable iff (srst)
      (|(flag_word & mask_reg)) |=> irq)
      else $error("interrupt not raised for enabled flag");
   sv_end_a: assert property (@(posedge sys_clk) disable iff (srst)
      (svsel_reg && !evt.sv_acc) |=> flag_word[BIT_SVEND])
      else $error("slave end flag missing after access");
   stretch_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      stretch_reg |-> (scl_oe && flag_word[BIT_STRETCH]))
      else $error("stretch flag and clock drive disagree");

endmodule
`default_nettype wire

// ===== rtl/isir_pkg.sv
// shared constants and types of the two-wire status and interrupt register block
package isir_pkg;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_CTRL       = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_FLAG       = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_IRQ_SET    = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLR    = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_RX_HOLD    = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_TX_HOLD    = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_FLAG_CLR   = 8'h38;
   localparam logic [ADDR_W-1:0] OFF_RX_CNT     = 8'h40;
   localparam logic [ADDR_W-1:0] OFF_RX_NEXT    = 8'h44;
   localparam logic [ADDR_W-1:0] OFF_TX_CNT     = 8'h48;
   localparam logic [ADDR_W-1:0] OFF_TX_NEXT    = 8'h4C;

   // ---------------------------------------------------------------
   // flag and control register bit positions
   // ---------------------------------------------------------------
   localparam int unsigned BIT_DONE    = 0;
   localparam int unsigned BIT_RXREADY = 1;
   localparam int unsigned BIT_TXFREE  = 2;
   localparam int unsigned BIT_SVREAD  = 3;
   localparam int unsigned BIT_SVSEL   = 4;
   localparam int unsigned BIT_GCALL   = 5;
   localparam int unsigned BIT_OVR     = 6;
   localparam int unsigned BIT_NACK    = 8;
   localparam int unsigned BIT_ARB     = 9;
   localparam int unsigned BIT_STRETCH = 10;
   localparam int unsigned BIT_SVEND   = 11;
   localparam int unsigned BIT_RXEND   = 12;
   localparam int unsigned BIT_TXEND   = 13;
   localparam int unsigned BIT_RXFULL  = 14;
   localparam int unsigned BIT_TXEMPTY = 15;
   localparam int unsigned BIT_MASTER  = 0;
   localparam int unsigned BIT_SLAVE   = 1;

   // ---------------------------------------------------------------
   // reset values and masks
   // ---------------------------------------------------------------
   localparam logic [31:0] FLAG_RST  = 32'h0000F009;
   localparam logic [31:0] IRQ_BITS  = 32'h0000FF77;
   localparam logic [31:0] MASK_RST  = 32'h00000000;
   localparam logic [31:0] CTRL_BITS = 32'h00000003;
   localparam logic [7:0]  BYTE_RST  = 8'h00;
   localparam int unsigned CNT_W     = 16;
   localparam int unsigned NCH       = 2;
   localparam int unsigned CH_RX     = 0;
   localparam int unsigned CH_TX     = 1;

   // events and levels from the serial bit engine, same clock
   typedef struct packed {
      logic       transfer_done;
      logic       sv_read;
      logic       sv_acc;
      logic       gen_call;
      logic       nack;
      logic       arb_lost;
      logic       rx_valid;
      logic [7:0] rx_byte;
      logic       tx_take;
      logic       char_due;
      logic [1:0] dma_xfer;
   } isir_evt_t;

endpackage

// ===== rtl/isir_dma_ctr.sv
// one peripheral dma counter pair with its end and buffer flags
`timescale 1ns/1ps
`default_nettype none
module isir_dma_ctr
   import isir_pkg::*;
#(
   parameter int unsigned W = CNT_W
) (
   input  wire logic         sys_clk,  // system clock
   input  wire logic         srst,     // sync reset
   input  wire logic         wr_cnt,   // write current count
   input  wire logic         wr_next,  // write next count
   input  wire logic [W-1:0] wdata,    // count value
   input  wire logic         xfer,     // one unit moved
   output logic      [W-1:0] cnt,      // current count
   output logic      [W-1:0] next_cnt, // next count
   output logic              end_flag, // count reached zero
   output logic              buf_flag  // both counts zero
);

   // ---------------------------------------------------------------
   // counter next values
   // ---------------------------------------------------------------
   logic [W-1:0] cnt_next;
   logic [W-1:0] nxt_next;
   logic         hit_zero;

   // decrement, reload from next count when the current one drains
   always_comb begin
      cnt_next = cnt;
      nxt_next = next_cnt;
      hit_zero = 1'b0;
      if (wr_cnt) begin
         cnt_next = wdata;
      end else if (xfer && cnt != '0) begin
         cnt_next = cnt - W'(1);
         hit_zero = (cnt == W'(1));
         if (hit_zero && next_cnt != '0) begin
            cnt_next = next_cnt;
            nxt_next = '0;
         end
      end
      if (wr_next) begin
         nxt_next = wdata;
      end
   end

   // counters and flags; reaching zero beats a next-count write in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt      <= '0;
         next_cnt <= '0;
         end_flag <= 1'b1;
         buf_flag <= 1'b1;
      end else begin
         cnt      <= cnt_next;
         next_cnt <= nxt_next;
         if (hit_zero) begin
            end_flag <= 1'b1;
         end else if (wr_cnt || wr_next) begin
            end_flag <= 1'b0;
         end
         buf_flag <= (cnt_next == '0) && (nxt_next == '0);
      end
   end

   drain_end_a: assert property (@(posedge sys_clk) disable iff (srst)
      (xfer && !wr_cnt && cnt == W'(1)) |=> end_flag)
      else $error("end flag not set after count drained");
   both_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 (buf_flag == (cnt == '0 && next_cnt == '0)))
      else $error("buffer flag disagrees with counters");

endmodule
`default_nettype wire

// ===== tb/isir_far_end.sv
// far-side bus party model: engine events and the serial clock it drives
`timescale 1ns/1ps
`default_nettype none
module isir_far_end
   import isir_pkg::*;
(
   input  wire logic      sys_clk, // system clock
   output var  isir_evt_t evt,     // engine events
   output logic           scl      // far clock drive, pulled up
);
   // idle: bus done, slave read direction, pulses low, clock high
   initial begin
      evt = '0;
      evt.transfer_done = 1'b1;
      evt.sv_read = 1'b1;
      scl = 1'b1;
   end

   // --------------------------------------------
   // one-cycle events; k 5 sets the access level
   // --------------------------------------------
   task automatic blip(input int k, input logic [7:0] b);
      @(posedge sys_clk);
      case (k)
         0: evt.rx_valid <= 1'b1;
         1: evt.tx_take <= 1'b1;
         2: evt.char_due <= 1'b1;
         5: evt.sv_acc <= b[0];
         default: evt.dma_xfer[k-3] <= 1'b1;
      endcase
      evt.rx_byte <= b;
      @(posedge sys_clk);
      evt.rx_valid <= 1'b0;
      evt.tx_take <= 1'b0;
      evt.char_due <= 1'b0;
      evt.dma_xfer <= 2'h0;
      evt.rx_byte <= ~b; // stale byte must not be relied on
   endtask

   // clock runs only inside a frame; left low, as between characters
   // eight system clocks per link period, 200 ns, changed on the edge
   task automatic frame(input int n);
      repeat (n) begin
         repeat (4) @(posedge sys_clk);
         scl <= 1'b0;
         repeat (4) @(posedge sys_clk);
         scl <= 1'b1;
      end
      repeat (4) @(posedge sys_clk);
      scl <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== tb/i2c_status_irq_regs_tb.sv
// self-checking bench for the status, interrupt and holding registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module i2c_status_irq_regs_tb
   import isir_pkg::*;
;
   logic              sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic              pwrite = 1'b0, s, pready, pslverr, tx_full, master_en;
   logic              slave_en, scl_o, scl_oe, irq, far_scl, scl_i;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata, r;
   logic [7:0]        tx_byte;
   isir_evt_t         evt;
   int                checks = 0, miscompares = 0;

   // open-drain clock: low if either party pulls it
   assign scl_i = far_scl & ~scl_oe;

   isir_regs DUT (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .evt, .tx_byte, .tx_full, .master_en,
      .slave_en, .scl_i, .scl_o, .scl_oe, .irq);
   isir_far_end far (.sys_clk(sys_clk), .evt(evt), .scl(far_scl));

   initial forever #12.5 sys_clk = ~sys_clk;

   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      `CHK(nm, e, g)
   endtask

   // --------------------------------------------
   // apb master: hold request until pready seen
   // --------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         miscompares++;
         report_and_stop();
      end
   endtask

   // flag read into r; only the low half may hold flags
   task automatic rdflag();
      apb(1'b0, OFF_FLAG, 32'h0);
      chk("flag_hi", 32'h0, r[31:16]);
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, r);
   endtask

   // bounded wait for the clock hold to reach a level
   task automatic wait_oe(input logic v);
      int n;
      for (n = 0; n < 40 && scl_oe !== v; n++) @(posedge sys_clk);
      chk("scl_oe", v, scl_oe);
      if (n >= 40) report_and_stop();
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      report_and_stop();
   end

   // --------------------------------------------
   // main sequence
   // --------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      rd("flag", OFF_FLAG, FLAG_RST);
      rd("mask", OFF_IRQ_MASK, MASK_RST);
      rd("txh", OFF_TX_HOLD, 32'h0);
      rd("rxh", OFF_RX_HOLD, 32'h0);
      rd("nomap", 8'hFC, 32'h0);
      chk("slverr", 32'h1, s);
      apb(1'b1, OFF_IRQ_SET, 32'hFFFFFFFF);
      rd("mask", OFF_IRQ_MASK, IRQ_BITS);
      chk("irq", 32'h1, irq);
      apb(1'b1, OFF_IRQ_CLR, 32'h000000FF);
      rd("mask", OFF_IRQ_MASK, 32'h0000FF00);
      apb(1'b1, OFF_IRQ_SET, 32'h0);
      rd("mask", OFF_IRQ_MASK, 32'h0000FF00);
      apb(1'b1, OFF_IRQ_CLR, 32'h0000F000);
      rd("mask", OFF_IRQ_MASK, 32'h00000F00);
      chk("irq", 32'h0, irq);
      // dma pairs: count down to zero, then a write to the next count
      for (int ch = 0; ch < 2; ch++) begin
         apb(1'b1, ch ? OFF_TX_CNT : OFF_RX_CNT, 32'h2);
         rdflag();
         chk("end", 32'h0, r[BIT_RXEND+ch]);
         chk("buf", 32'h0, r[BIT_RXFULL+ch]);
         repeat (2) far.blip(3 + ch, 8'h0);
         rdflag();
         chk("end", 32'h1, r[BIT_RXEND+ch]);
         chk("buf", 32'h1, r[BIT_RXFULL+ch]);
         apb(1'b1, ch ? OFF_TX_NEXT : OFF_RX_NEXT, 32'h0);
         rdflag();
         chk("end", 32'h0, r[BIT_RXEND+ch]);
         chk("buf", 32'h1, r[BIT_RXFULL+ch]);
      end
      far.blip(0, 8'hA5);
      rd("rxh", OFF_RX_HOLD, 32'h000000A5);
      apb(1'b1, OFF_TX_HOLD, 32'hFFFFFF3C);
      rd("txh", OFF_TX_HOLD, 32'h0000003C);
      chk("txb", 32'h3C, tx_byte);
      chk("txfull", 32'h1, tx_full);
      // slave read access stalls on a free holding register
      apb(1'b1, OFF_CTRL, 32'h2);
      far.blip(5, 8'h1);
      far.blip(1, 8'h0);
      far.frame(2);
      far.blip(2, 8'h0);
      wait_oe(1'b1);
      chk("scl_o", 32'h0, scl_o);
      chk("slave_en", 32'h1, slave_en);
      chk("master_en", 32'h0, master_en);
      rdflag();
      chk("stretch", 32'h1, r[BIT_STRETCH]);
      chk("svend", 32'h0, r[BIT_SVEND]);
      chk("irq", 32'h1, irq);
      apb(1'b1, OFF_TX_HOLD, 32'h55);
      wait_oe(1'b0);
      rdflag();
      chk("stretch", 32'h0, r[BIT_STRETCH]);
      far.blip(5, 8'h0);
      repeat (3) @(posedge sys_clk);
      chk("irq", 32'h1, irq);
      rdflag();
      chk("svend", 32'h1, r[BIT_SVEND]);
      rdflag();
      chk("svend", 32'h0, r[BIT_SVEND]);
      report_and_stop();
   end
endmodule
`default_nettype wire
